/* File: can_timing_params.svh */
`ifndef CAN_TIMING_PARAMS_SVH
`define CAN_TIMING_PARAMS_SVH

// Register byte offsets
`define OFS_BTC1 8'h00
`define OFS_BTC2 8'h04
`define OFS_BTC3 8'h08
`define OFS_MODE 8'h0c
`define OFS_STAT 8'h10

// Field positions
`define BTC1_SJW_HI 7
`define BTC1_SJW_LO 6
`define BTC1_BRP_HI 5
`define BTC1_BRP_LO 0
`define BTC2_PH2FREE 7
`define BTC2_TRIPLE 6
`define BTC2_PH1_HI 5
`define BTC2_PH1_LO 3
`define BTC2_PROP_HI 2
`define BTC2_PROP_LO 0
`define BTC3_BUS_WAKE_DISABLE 7
`define BTC3_WAKE_LINE_FILTER_SELECT 6
`define BTC3_PH2_HI 2
`define BTC3_PH2_LO 0
`define BTC3_MASK 8'hc7
`define MODE_CFG 0
`define MODE_SLEEP 1
`define STAT_CFG 0
`define STAT_WAKE 1
`define STAT_SAMPLE 2

// Reset values
`define BTC_RST 8'h00
`define MODE_RST 2'h1

// Information processing time in quanta
`define IPT_TQ 4'h2
// Consecutive dominant clocks accepted by the wake line filter
`define WAKE_FILT_CYCLES 6'h0a

`endif

/* File: can_timing_pkg.sv */
package can_timing_pkg;
  typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} bit_seg_t;
  typedef enum logic [2:0] {SEL_BTC1, SEL_BTC2, SEL_BTC3, SEL_MODE, SEL_STAT,
                            SEL_NONE} reg_sel_t;
endpackage : can_timing_pkg

/* File: tq_prescaler.sv */
`timescale 1ns/1ps
`include "can_timing_params.svh"
module tq_prescaler (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic run,
  input wire logic [5:0] prescaler_value,
  // Quantum tick
  output logic tq_tick
);
  logic [6:0] cnt_reg;
  logic [6:0] term;

  // Quantum is 2 x (value + 1) clocks
  assign term = {prescaler_value, 1'b1};
  assign tq_tick = run && (cnt_reg == term);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 7'h00;
    end else if (!run || tq_tick) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
    end
  end
endmodule : tq_prescaler

/* File: wake_line_filter.sv */
`timescale 1ns/1ps
`include "can_timing_params.svh"
module wake_line_filter (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus line
  input wire logic can_rx,
  // Filtered result
  output logic dominant_filt
);
  logic [5:0] run_reg;

  // Dominant only after a steady low run, so glitches do not wake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg <= 6'h00;
    end else if (can_rx) begin
      run_reg <= 6'h00;
    end else if (run_reg != `WAKE_FILT_CYCLES) begin
      run_reg <= run_reg + 6'h01;
    end
  end

  assign dominant_filt = (run_reg == `WAKE_FILT_CYCLES);
endmodule : wake_line_filter

/* File: can_bit_timing_config.sv */
// Summary of operation
// - Timing registers writable only in configuration mode
// - Jump width is field plus one quanta
// - Quantum equals two times prescaler plus one
// - Free select picks programmed or automatic phase two
// - Triple select samples three times before point
// - Phase one is field plus one quanta
// - Propagation is field plus one quanta
// - Phase two is field plus one quanta
// - Phase two field ignored when free select clear
// - Wake disable blocks bus activity wake-up
// - Filter select routes wake through line filter
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "can_timing_params.svh"
module can_bit_timing_config (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // CAN line
  input wire logic can_rx,
  // Bit timing status
  output logic tq_tick,
  output logic bit_start,
  output logic sample_point,
  output logic rx_sample,
  output can_timing_pkg::bit_seg_t seg_state,
  // Wake-up
  output logic wake_request
);
  import can_timing_pkg::*;

  function automatic reg_sel_t decode_addr(input logic [31:0] addr);
    if (addr[31:8] != 24'h000000) begin
      decode_addr = SEL_NONE;
    end else if (addr[7:0] == `OFS_BTC1) begin
      decode_addr = SEL_BTC1;
    end else if (addr[7:0] == `OFS_BTC2) begin
      decode_addr = SEL_BTC2;
    end else if (addr[7:0] == `OFS_BTC3) begin
      decode_addr = SEL_BTC3;
    end else if (addr[7:0] == `OFS_MODE) begin
      decode_addr = SEL_MODE;
    end else if (addr[7:0] == `OFS_STAT) begin
      decode_addr = SEL_STAT;
    end else begin
      decode_addr = SEL_NONE;
    end
  endfunction : decode_addr

  logic [7:0] btc1_reg;
  logic [7:0] btc2_reg;
  logic [7:0] btc3_reg;
  logic [1:0] mode_reg;
  logic wake_flag_reg;
  logic sample_reg;
  logic [31:0] hrdata_reg;
  logic wr_pend_reg;
  reg_sel_t wr_sel_reg;
  logic addr_ok;
  logic cfg_mode;
  logic wr_stat;
  bit_seg_t state_reg;
  logic [3:0] q_cnt_reg;
  logic [3:0] elapsed_reg;
  logic [3:0] ext_reg;
  logic [3:0] short_reg;
  logic resync_done_reg;
  logic rx_prev_reg;
  logic [2:0] rx_hist_reg;
  logic [3:0] sjw_q;
  logic [3:0] prop_len;
  logic [3:0] ph1_base;
  logic [3:0] ph1_len;
  logic [3:0] ph2_prog;
  logic [3:0] ph2_auto;
  logic [3:0] ph2_eff;
  logic [3:0] ph2_len;
  logic [3:0] seg_len;
  logic [3:0] ph2_rem;
  logic [3:0] err_q;
  logic seg_end;
  logic rx_fall;
  logic run;
  logic dominant_filt;
  logic wake_dominant;
  logic wake_set;
  logic majority;

  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign addr_ok = hsel && hready && htrans[1];
  assign cfg_mode = mode_reg[`MODE_CFG];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_sel_reg <= SEL_NONE;
    end else if (hready) begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_sel_reg <= decode_addr(haddr);
    end
  end

  // Read data captured in address phase, stands in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      if (decode_addr(haddr) == SEL_BTC1) begin
        hrdata_reg <= {24'h000000, btc1_reg};
      end else if (decode_addr(haddr) == SEL_BTC2) begin
        hrdata_reg <= {24'h000000, btc2_reg};
      end else if (decode_addr(haddr) == SEL_BTC3) begin
        hrdata_reg <= {24'h000000, btc3_reg};
      end else if (decode_addr(haddr) == SEL_MODE) begin
        hrdata_reg <= {30'h00000000, mode_reg};
      end else if (decode_addr(haddr) == SEL_STAT) begin
        hrdata_reg <= {29'h00000000, sample_reg, wake_flag_reg, cfg_mode};
      end else begin
        hrdata_reg <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      btc1_reg <= `BTC_RST;
      btc2_reg <= `BTC_RST;
      btc3_reg <= `BTC_RST;
    end else if (wr_pend_reg && cfg_mode) begin
      if (wr_sel_reg == SEL_BTC1) begin
        btc1_reg <= hwdata[7:0];
      end else if (wr_sel_reg == SEL_BTC2) begin
        btc2_reg <= hwdata[7:0];
      end else if (wr_sel_reg == SEL_BTC3) begin
        btc3_reg <= hwdata[7:0] & `BTC3_MASK;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= `MODE_RST;
    end else if (wr_pend_reg && wr_sel_reg == SEL_MODE) begin
      mode_reg <= hwdata[1:0];
    end
  end

  // Field decoding into quanta
  assign sjw_q = {2'b00, btc1_reg[`BTC1_SJW_HI:`BTC1_SJW_LO]} + 4'h1;
  assign prop_len = {1'b0, btc2_reg[`BTC2_PROP_HI:`BTC2_PROP_LO]} + 4'h1;
  assign ph1_base = {1'b0, btc2_reg[`BTC2_PH1_HI:`BTC2_PH1_LO]} + 4'h1;
  assign ph1_len = ph1_base + ext_reg;
  assign ph2_prog = {1'b0, btc3_reg[`BTC3_PH2_HI:`BTC3_PH2_LO]} + 4'h1;
  assign ph2_auto = (ph1_base > `IPT_TQ) ? ph1_base : `IPT_TQ;
  assign ph2_eff = btc2_reg[`BTC2_PH2FREE] ? ph2_prog : ph2_auto;
  assign ph2_len = ph2_eff - short_reg;
  assign ph2_rem = ph2_len - q_cnt_reg;
  assign run = !cfg_mode;

  tq_prescaler u_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run),
    .prescaler_value(btc1_reg[`BTC1_BRP_HI:`BTC1_BRP_LO]),
    .tq_tick(tq_tick)
  );

  always_comb begin
    case (state_reg)
      SEG_SYNC: seg_len = 4'h1;
      SEG_PROP: seg_len = prop_len;
      SEG_PH1: seg_len = ph1_len;
      default: seg_len = ph2_len;
    endcase
  end

  assign seg_end = tq_tick && (q_cnt_reg + 4'h1 >= seg_len);
  assign rx_fall = rx_prev_reg && !can_rx;

  // Segment sequencer: one sync quantum, then prop, phase 1, phase 2
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= SEG_SYNC;
      q_cnt_reg <= 4'h0;
    end else if (!run) begin
      state_reg <= SEG_SYNC;
      q_cnt_reg <= 4'h0;
    end else if (seg_end) begin
      q_cnt_reg <= 4'h0;
      case (state_reg)
        SEG_SYNC: state_reg <= SEG_PROP;
        SEG_PROP: state_reg <= SEG_PH1;
        SEG_PH1: state_reg <= SEG_PH2;
        default: state_reg <= SEG_SYNC;
      endcase
    end else if (tq_tick) begin
      q_cnt_reg <= q_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      elapsed_reg <= 4'h0;
    end else if (!run || state_reg == SEG_SYNC) begin
      elapsed_reg <= 4'h0;
    end else if (tq_tick && elapsed_reg != 4'hf) begin
      elapsed_reg <= elapsed_reg + 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= can_rx;
    end
  end

  // Resync: late edge stretches phase 1, early edge trims phase 2
  assign err_q = elapsed_reg + 4'h1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_reg <= 4'h0;
      short_reg <= 4'h0;
      resync_done_reg <= 1'b0;
    end else if (!run || (seg_end && state_reg == SEG_PH2)) begin
      ext_reg <= 4'h0;
      short_reg <= 4'h0;
      resync_done_reg <= 1'b0;
    end else if (rx_fall && !resync_done_reg && state_reg != SEG_SYNC) begin
      resync_done_reg <= 1'b1;
      if (state_reg == SEG_PH2) begin
        short_reg <= short_reg + (((ph2_rem - 4'h1) < sjw_q) ? (ph2_rem - 4'h1) : sjw_q);
      end else begin
        ext_reg <= (err_q < sjw_q) ? err_q : sjw_q;
      end
    end
  end

  // Quantum-spaced history for triple sampling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_hist_reg <= 3'h7;
    end else if (tq_tick) begin
      rx_hist_reg <= {rx_hist_reg[1:0], can_rx};
    end
  end

  assign majority = (rx_hist_reg[0] & rx_hist_reg[1]) | (rx_hist_reg[0] & rx_hist_reg[2])
                  | (rx_hist_reg[1] & rx_hist_reg[2]);
  assign sample_point = run && seg_end && state_reg == SEG_PH1;
  assign bit_start = run && seg_end && state_reg == SEG_PH2;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_reg <= 1'b1;
    end else if (sample_point) begin
      sample_reg <= btc2_reg[`BTC2_TRIPLE] ? majority : can_rx;
    end
  end

  assign rx_sample = sample_reg;
  assign seg_state = state_reg;

  // Wake-up on bus activity while asleep
  wake_line_filter u_wake_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .can_rx(can_rx),
    .dominant_filt(dominant_filt)
  );

  assign wake_dominant = btc3_reg[`BTC3_WAKE_LINE_FILTER_SELECT] ? dominant_filt : !can_rx;
  assign wake_set = mode_reg[`MODE_SLEEP] && !btc3_reg[`BTC3_BUS_WAKE_DISABLE] && wake_dominant;
  assign wr_stat = wr_pend_reg && wr_sel_reg == SEL_STAT && hwdata[`STAT_WAKE];

  // Set wins over a write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_flag_reg <= 1'b0;
    end else if (wake_set) begin
      wake_flag_reg <= 1'b1;
    end else if (wr_stat) begin
      wake_flag_reg <= 1'b0;
    end
  end

  assign wake_request = wake_flag_reg;

  // Checks
  logic [7:0] gap_reg;
  logic gap_ok_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_reg <= 8'h00;
      gap_ok_reg <= 1'b0;
    end else if (!run || wr_pend_reg) begin
      gap_reg <= 8'h00;
      gap_ok_reg <= 1'b0;
    end else if (tq_tick) begin
      gap_reg <= 8'h00;
      gap_ok_reg <= 1'b1;
    end else begin
      gap_reg <= gap_reg + 8'h01;
    end
  end

  a_timing_write_lock: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_reg && !cfg_mode) |=> $stable(btc1_reg) && $stable(btc2_reg) && $stable(btc3_reg))
    else $error("timing register changed outside configuration mode");
  a_quantum_period: assert property (@(posedge hclk) disable iff (!hresetn)
    (tq_tick && gap_ok_reg) |-> gap_reg == {1'b0, btc1_reg[5:0], 1'b1})
    else $error("quantum period differs from prescaler setting");
  a_prop_length: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && state_reg == SEG_SYNC && tq_tick ##1 (run && !wr_pend_reg)[*1])
    |-> state_reg == SEG_PROP && q_cnt_reg == 4'h0)
    else $error("propagation segment did not follow sync quantum");

  a_ph2_auto_len: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_reg == SEG_PH2 && seg_end && !btc2_reg[7] && short_reg == 4'h0)
    |-> q_cnt_reg + 4'h1 == (({1'b0, btc2_reg[5:3]} + 4'h1 > `IPT_TQ) ?
                             {1'b0, btc2_reg[5:3]} + 4'h1 : `IPT_TQ))
    else $error("automatic phase 2 length wrong");
  a_jump_width_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    ext_reg <= {2'b00, btc1_reg[7:6]} + 4'h1 && short_reg <= {2'b00, btc1_reg[7:6]} + 4'h1)
    else $error("resync adjustment exceeds jump width");
  a_single_sample: assert property (@(posedge hclk) disable iff (!hresetn)
    (sample_point && !btc2_reg[6]) |=> rx_sample == $past(can_rx))
    else $error("single sample does not match line at sample point");
  a_triple_sample: assert property (@(posedge hclk) disable iff (!hresetn)
    (sample_point && btc2_reg[6] && rx_hist_reg == 3'h0) |=> !rx_sample)
    else $error("triple sample majority wrong");

  a_wake_disabled: assert property (@(posedge hclk) disable iff (!hresetn)
    (btc3_reg[7] && !wake_request && !wr_pend_reg) |=> !wake_request)
    else $error("wake-up raised while disabled");
  a_wake_filtered: assert property (@(posedge hclk) disable iff (!hresetn)
    (btc3_reg[6] && $rose(wake_request)) |-> $past(dominant_filt))
    else $error("wake-up bypassed the line filter");

  a_seg_order: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && state_reg == SEG_PH1 && seg_end) |-> sample_point ##1 state_reg == SEG_PH2)
    else $error("sample point not at end of phase 1");

  c_resync_late: cover property (@(posedge hclk) disable iff (!hresetn)
    rx_fall && run && state_reg == SEG_PH1);
  c_resync_early: cover property (@(posedge hclk) disable iff (!hresetn)
    rx_fall && run && state_reg == SEG_PH2);
  c_wake: cover property (@(posedge hclk) disable iff (!hresetn) $rose(wake_request));
  c_triple: cover property (@(posedge hclk) disable iff (!hresetn)
    sample_point && btc2_reg[6]);
endmodule : can_bit_timing_config

/* File: bus_node_model.sv */
`timescale 1ns/1ps
module bus_node_model (
  // Clock
  input wire logic hclk,
  // Line toward the receiver
  output logic can_rx
);
  // Transceiver idles recessive
  initial can_rx = 1'b1;

  // Hold one level for a number of clocks, return just past an edge
  task automatic hold_level(input logic lvl, input int cycles);
    @(posedge hclk);
    can_rx <= lvl;
    repeat (cycles) @(posedge hclk);
    #1;
  endtask : hold_level
endmodule : bus_node_model

/* File: tb_can_bit_timing_config.sv */
`timescale 1ns/1ps
`include "can_timing_params.svh"
module tb_can_bit_timing_config;
  import can_timing_pkg::*;
  localparam int info_quanta = 2;
  localparam int cycle_limit = 20000;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic can_rx;
  logic tq_tick;
  logic bit_start;
  logic sample_point;
  logic rx_sample;
  bit_seg_t seg_state;
  logic wake_request;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [23:0] cases [5] = '{24'hff8000, 24'h008000, 24'h018a02, 24'h011807, 24'h010005};
  logic [7:0] modes [2] = '{8'h80, 8'hc0};

  can_bit_timing_config can_bit_timing_config_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .can_rx(can_rx),
    .tq_tick(tq_tick), .bit_start(bit_start), .sample_point(sample_point),
    .rx_sample(rx_sample), .seg_state(seg_state), .wake_request(wake_request)
  );

  bus_node_model bus_node_model_i (
    .hclk(hclk),
    .can_rx(can_rx)
  );

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == cycle_limit) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check_word(input string what, input logic [31:0] exp,
                            input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_count(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      failures++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_count

  // Single transfer: address phase, then data phase, each ends on hready
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check_word("hresp", 32'h0, {31'h0, hresp});
  endtask : bus_xfer

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus_xfer(1'b1, a, d, unused);
  endtask : bus_write

  task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] got;
    bus_xfer(1'b0, a, 32'h0, got);
    check_word($sformatf("register %h", a), exp, got);
  endtask : check_reg

  // Enter configuration mode, load timing, leave it again
  task automatic setup(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
    bus_write(`OFS_MODE, 32'h1);
    bus_write(`OFS_BTC1, {24'h0, b1});
    bus_write(`OFS_BTC2, {24'h0, b2});
    bus_write(`OFS_BTC3, {24'h0, b3});
    bus_write(`OFS_MODE, 32'h0);
  endtask : setup

  task automatic step();
    @(posedge hclk);
    #1;
  endtask : step

  task automatic wait_bit(output int c);
    c = 0;
    do begin
      step();
      c++;
    end while (bit_start !== 1'b1 && c < 6000);
  endtask : wait_bit

  task automatic run_timing(input logic [7:0] b1, input logic [7:0] b2,
                            input logic [7:0] b3);
    int q;
    int p1;
    int p2;
    int samp;
    int c;
    int t;
    int s;
    q = 2 * (int'(b1[5:0]) + 1);
    p1 = int'(b2[5:3]) + 1;
    samp = 1 + int'(b2[2:0]) + 1 + p1;
    p2 = b2[7] ? int'(b3[2:0]) + 1 : (p1 > info_quanta ? p1 : info_quanta);
    setup(b1, b2, b3);
    wait_bit(c);
    c = 0;
    t = 0;
    s = 0;
    do begin
      step();
      c++;
      if (tq_tick === 1'b1 && t == 0) t = c;
      if (sample_point === 1'b1) s = c;
    end while (bit_start !== 1'b1 && c < 6000);
    check_count("quantum clocks", q, t);
    check_count("sample point", samp * q, s);
    check_count("bit clocks", (samp + p2) * q, c);
  endtask : run_timing

  initial begin
    int c;
    logic [31:0] rd;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    check_word("seg_state", {30'h0, SEG_SYNC}, {30'h0, seg_state});
    check_reg(`OFS_BTC1, 32'h0);
    check_reg(`OFS_BTC2, 32'h0);
    check_reg(`OFS_BTC3, 32'h0);
    check_reg(`OFS_MODE, 32'h1);
    check_reg(8'h14, 32'h0);
    $display("test reset done");

    setup(8'hff, 8'hff, 8'hff);
    check_reg(`OFS_BTC1, 32'hff);
    check_reg(`OFS_BTC2, 32'hff);
    check_reg(`OFS_BTC3, 32'hc7);
    bus_write(8'h14, 32'hff);
    check_reg(8'h14, 32'h0);
    bus_write(`OFS_BTC1, 32'h0);
    bus_write(`OFS_BTC2, 32'h0);
    bus_write(`OFS_BTC3, 32'h0);
    check_reg(`OFS_BTC1, 32'hff);
    check_reg(`OFS_BTC2, 32'hff);
    check_reg(`OFS_BTC3, 32'hc7);
    $display("test access done");

    for (int i = 0; i < 5; i++) begin
      run_timing(cases[i][23:16], cases[i][15:8], cases[i][7:0]);
    end
    $display("test timing done");

    // Nominal bit of 10 quanta, 2 clocks each, jump width 2 quanta
    setup(8'h40, 8'h98, 8'h03);
    wait_bit(c);
    bus_node_model_i.hold_level(1'b1, 5);
    bus_node_model_i.hold_level(1'b0, 1);
    wait_bit(c);
    check_count("late edge bit clocks", (10 + 2) * 2, c + 8);
    bus_node_model_i.hold_level(1'b1, 11);
    bus_node_model_i.hold_level(1'b0, 1);
    wait_bit(c);
    check_count("early edge bit clocks", (10 - 2) * 2, c + 14);
    $display("test resync done");

    foreach (modes[i]) begin
      for (int v = 0; v < 2; v++) begin
        setup(8'h00, modes[i], 8'h00);
        bus_node_model_i.hold_level(v[0], 1);
        wait_bit(c);
        wait_bit(c);
        check_word("rx_sample", {31'h0, v[0]}, {31'h0, rx_sample});
        bus_xfer(1'b0, `OFS_STAT, 32'h0, rd);
        check_word("status sample", {31'h0, v[0]}, {31'h0, rd[`STAT_SAMPLE]});
      end
    end
    $display("test sampling done");

    foreach (modes[i]) begin
      setup(8'h00, modes[i], 8'h00);
      wait_bit(c);
      // Dominant in the sample point cycle and the one after it
      bus_node_model_i.hold_level(1'b1, 4);
      bus_node_model_i.hold_level(1'b0, 1);
      check_word("glitch sample", {31'h0, modes[i][6]}, {31'h0, rx_sample});
      bus_node_model_i.hold_level(1'b1, 2);
    end
    $display("test glitch done");

    bus_write(`OFS_MODE, 32'h1);
    bus_write(`OFS_BTC3, 32'h80);
    bus_write(`OFS_MODE, 32'h3);
    bus_node_model_i.hold_level(1'b0, 20);
    bus_node_model_i.hold_level(1'b1, 2);
    check_word("wake disabled", 32'h0, {31'h0, wake_request});
    bus_write(`OFS_BTC3, 32'h40);
    bus_node_model_i.hold_level(1'b0, int'(`WAKE_FILT_CYCLES) - 3);
    bus_node_model_i.hold_level(1'b1, 2);
    check_word("wake short", 32'h0, {31'h0, wake_request});
    bus_node_model_i.hold_level(1'b0, int'(`WAKE_FILT_CYCLES) + 2);
    bus_node_model_i.hold_level(1'b1, 2);
    check_word("wake long", 32'h1, {31'h0, wake_request});
    bus_xfer(1'b0, `OFS_STAT, 32'h0, rd);
    check_word("status wake", 32'h1, {31'h0, rd[`STAT_WAKE]});
    bus_write(`OFS_STAT, 32'h2);
    step();
    check_word("wake cleared", 32'h0, {31'h0, wake_request});
    bus_write(`OFS_BTC3, 32'h00);
    bus_node_model_i.hold_level(1'b0, 1);
    bus_node_model_i.hold_level(1'b1, 2);
    check_word("wake unfiltered", 32'h1, {31'h0, wake_request});
    $display("test wake done");
    report_and_stop();
  end
endmodule : tb_can_bit_timing_config
